// File: rtl/gp_pkg.sv
// constants and carrier types shared by the gpio port block
package gp_pkg;
    // register indices; the byte address on the bus is four times the index
    localparam logic [7:0] IDX_P4_CFG = 8'hAE;
    localparam logic [7:0] IDX_VREF = 8'hAF;
    localparam logic [7:0] IDX_ADM = 8'hB1;
    localparam logic [7:0] IDX_P0_DIR = 8'hB8;
    localparam logic [7:0] IDX_P4_DIR = 8'hC4;
    localparam logic [7:0] IDX_P5_DIR = 8'hC5;
    localparam logic [7:0] IDX_P0_DAT = 8'hD0;
    localparam logic [7:0] IDX_P4_DAT = 8'hD4;
    localparam logic [7:0] IDX_P5_DAT = 8'hD5;
    localparam logic [7:0] IDX_P0_PU = 8'hE0;
    localparam logic [7:0] IDX_P4_PU = 8'hE4;
    localparam logic [7:0] IDX_P5_PU = 8'hE5;
    localparam logic [7:0] IDX_OPTION = 8'hF0;
    localparam logic [7:0] IDX_SHARE = 8'hF1;
    localparam logic [7:0] RST_VAL = 8'h00;
    localparam logic [7:0] ADM_MASK = 8'hF7;
    localparam logic [7:0] VREF_MASK = 8'h83;
    localparam logic [7:0] OPT_MASK = 8'h3F;
    localparam int ADM_EN_BIT = 7;
    localparam int ADM_GLOBAL_CHANNEL_SELECT_BIT = 4;
    localparam int VREF_EN_BIT = 7;
    localparam int OPT_RST_BIT = 0;
    localparam int OPT_HCLK_LSB = 1;
    localparam int OPT_EDGE_LSB = 4;
    localparam int SH_T0_EN = 0;
    localparam int SH_T1_EN = 1;
    localparam int SH_TIMER0_PWM_PIN = 2;
    localparam int SH_TIMER1_PWM_PIN = 3;
    localparam int SH_BUZ0 = 4;
    localparam int SH_BUZ1 = 5;
    localparam int SH_EXTERNAL_INTERRUPT_0_EN = 6;
    localparam int SH_EXTERNAL_INTERRUPT_1_EN = 7;
    localparam logic [2:0] CH_INTERNAL = 3'h5;
    localparam logic [2:0] HCLK_RC = 3'h1;
    localparam logic [2:0] HCLK_32K = 3'h2;
    localparam logic [2:0] HCLK_4M = 3'h3;
    localparam logic [2:0] HCLK_12M = 3'h4;
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef struct packed {
        logic awvalid;
        logic [11:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [11:0] araddr;
        logic rready;
    } gp_axil_req_s;
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } gp_axil_rsp_s;
endpackage : gp_pkg

// File: rtl/gp_pin_cell.sv
// per-pin steering of direction, pull-up, shared output and analog isolation
`timescale 1ns/10ps
module gp_pin_cell #(
    parameter int W = 1
) (
    input wire logic [W-1:0] dir_in,
    input wire logic [W-1:0] pu_in,
    input wire logic [W-1:0] lat_in,
    input wire logic [W-1:0] alt_en_in,
    input wire logic [W-1:0] alt_val_in,
    input wire logic [W-1:0] analog_in,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] pin_out,
    output logic [W-1:0] oe_out,
    output logic [W-1:0] pu_out,
    output logic [W-1:0] rd_out
);
    // an analog pin has every digital path cut, including readback
    always_comb begin
        oe_out = ~analog_in & (dir_in | alt_en_in);
        pin_out = ~analog_in & ((alt_en_in & alt_val_in) | (~alt_en_in & lat_in));
        pu_out = pu_in & ~dir_in & ~alt_en_in & ~analog_in;
        rd_out = ~analog_in & ((dir_in & lat_in) | (~dir_in & pin_in));
    end
endmodule : gp_pin_cell

// File: rtl/gp_axil_slave.sv
// axi4-lite slave front end: one write and one read in flight at most
`timescale 1ns/10ps
module gp_axil_slave (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire gp_pkg::gp_axil_req_s req_in,
    output gp_pkg::gp_axil_rsp_s rsp_out,
    output logic wr_en_out,
    output logic [7:0] wr_idx_out,
    output logic [7:0] wr_data_out,
    output logic [7:0] rd_idx_out,
    input wire logic [7:0] rd_data_in,
    input wire logic wr_hit_in,
    input wire logic rd_hit_in
);
    typedef struct packed {
        logic aw_ok;
        logic w_ok;
        logic [11:0] waddr;
        logic [7:0] wdata;
        logic wlane;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
    } gp_bus_s;
    gp_bus_s s_ff;
    gp_bus_s s_nxt;
    logic wr_go;
    logic wr_ok;
    logic rd_ok;
    logic ar_take;

    always_comb begin
        rsp_out.awready = ~s_ff.aw_ok & ~s_ff.bvalid;
        rsp_out.wready = ~s_ff.w_ok & ~s_ff.bvalid;
        rsp_out.bvalid = s_ff.bvalid;
        rsp_out.bresp = s_ff.bresp;
        rsp_out.arready = ~s_ff.rvalid;
        rsp_out.rvalid = s_ff.rvalid;
        rsp_out.rdata = {24'h000000, s_ff.rdata};
        rsp_out.rresp = s_ff.rresp;
        wr_idx_out = s_ff.waddr[9:2];
        wr_data_out = s_ff.wdata;
        rd_idx_out = req_in.araddr[9:2];
        wr_go = s_ff.aw_ok & s_ff.w_ok;
        wr_ok = wr_hit_in & (s_ff.waddr[11:10] == 2'h0);
        rd_ok = rd_hit_in & (req_in.araddr[11:10] == 2'h0);
        // only the low byte lane carries register data
        wr_en_out = wr_go & wr_ok & s_ff.wlane;
        ar_take = req_in.arvalid & ~s_ff.rvalid;
    end

    always_comb begin
        s_nxt = s_ff;
        if (req_in.awvalid && rsp_out.awready) begin
            s_nxt.aw_ok = 1'b1;
            s_nxt.waddr = req_in.awaddr;
        end
        if (req_in.wvalid && rsp_out.wready) begin
            s_nxt.w_ok = 1'b1;
            s_nxt.wdata = req_in.wdata[7:0];
            s_nxt.wlane = req_in.wstrb[0];
        end
        if (wr_go) begin
            s_nxt.aw_ok = 1'b0;
            s_nxt.w_ok = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = wr_ok ? gp_pkg::RESP_OKAY : gp_pkg::RESP_SLVERR;
        end else if (s_ff.bvalid && req_in.bready) begin
            s_nxt.bvalid = 1'b0;
        end
        if (ar_take) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata = rd_ok ? rd_data_in : 8'h00;
            s_nxt.rresp = rd_ok ? gp_pkg::RESP_OKAY : gp_pkg::RESP_SLVERR;
        end else if (s_ff.rvalid && req_in.rready) begin
            s_nxt.rvalid = 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            s_ff <= '0;
        end else begin
            s_ff <= s_nxt;
        end
    end
endmodule : gp_axil_slave

// File: rtl/gp_gpio_top.sv
// gpio ports 0, 4 and 5 with shared-function steering and register file
`timescale 1ns/10ps
// Function
// - direction bit 0 input, 1 output
// - pull-up only when enabled and input
// - port 0 bit 4 never drives
// - port 0 bit 4 has no pull-up
// - reset option makes port 0 bit 4 read 1
// - port 0 bit 4 is reset when optioned
// - oscillator option claims port 0 bit 3, and bit 2 except for rc
// - port 5 bit 3 carries timer 1 pwm/buzzer
// - port 5 bit 4 carries timer 0 pwm/buzzer
// - port 4 config bit makes pure analog pin
// - global select 0 keeps port 4 digital
// - enabled converter claims selected port 4 pin
// - channels 0-4 are pins, 5 internal
// - at most one port 4 pin routed
// - external reference claims port 4 bit 0
// - all control bits reset to zero
// - external_interrupt_1 falling edge only, external_interrupt_0 selectable
module gp_gpio_top (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire gp_pkg::gp_axil_req_s axil_req_in,
    output gp_pkg::gp_axil_rsp_s axil_rsp_out,
    input wire logic [4:0] p0_pin_in,
    output logic [3:0] p0_pin_out,
    output logic [3:0] p0_oe_out,
    output logic [3:0] p0_pu_out,
    input wire logic [4:0] p4_pin_in,
    output logic [4:0] p4_pin_out,
    output logic [4:0] p4_oe_out,
    output logic [4:0] p4_pu_out,
    output logic [4:0] p4_ain_out,
    output logic p4_vref_out,
    input wire logic [1:0] p5_pin_in,
    output logic [1:0] p5_pin_out,
    output logic [1:0] p5_oe_out,
    output logic [1:0] p5_pu_out,
    input wire logic t0_pwm_in,
    input wire logic t0_buzz_in,
    input wire logic t1_pwm_in,
    input wire logic t1_buzz_in,
    output logic adc_enable_out,
    output logic adc_internal_ch_out,
    output logic ext_reset_out,
    output logic osc_in_sel_out,
    output logic osc_out_sel_out,
    output logic external_interrupt_0_level_out,
    output logic external_interrupt_1_level_out,
    output logic external_interrupt_0_pulse_out,
    output logic external_interrupt_1_pulse_out
);
    typedef struct packed {
        logic [4:0] p4_cfg;
        logic [7:0] vref;
        logic [7:0] adc_mode_control;
        logic [3:0] p0_dir;
        logic [4:0] p4_dir;
        logic [1:0] p5_dir;
        logic [3:0] p0_lat;
        logic [4:0] p4_lat;
        logic [1:0] p5_lat;
        logic [3:0] p0_pu;
        logic [4:0] p4_pu;
        logic [1:0] p5_pu;
        logic [7:0] opt;
        logic [7:0] share;
        logic [1:0] int_prev;
        logic [1:0] int_pls;
    } gp_state_s;

    gp_state_s s_ff;
    gp_state_s s_nxt;
    logic wr_en;
    logic [7:0] wr_idx;
    logic [7:0] wr_dat;
    logic [7:0] rd_idx;
    logic [7:0] rd_data;
    logic wr_hit;
    logic rd_hit;
    logic opt_rst;
    logic [2:0] hclk;
    logic [1:0] external_interrupt_0_edge;
    logic conv_on;
    logic [2:0] chs;
    logic vref_en;
    logic [4:0] p4_ana;
    logic [1:0] p5_alt_en;
    logic [1:0] p5_alt_val;
    logic t0_pwm_on;
    logic t1_pwm_on;
    logic [3:0] p0_rd;
    logic [4:0] p4_rd;
    logic [1:0] p5_rd;
    logic fell0;
    logic rose0;
    logic fell1;

    gp_axil_slave u_bus (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .req_in(axil_req_in),
        .rsp_out(axil_rsp_out),
        .wr_en_out(wr_en),
        .wr_idx_out(wr_idx),
        .wr_data_out(wr_dat),
        .rd_idx_out(rd_idx),
        .rd_data_in(rd_data),
        .wr_hit_in(wr_hit),
        .rd_hit_in(rd_hit)
    );

    // shared-function selects
    always_comb begin
        opt_rst = s_ff.opt[gp_pkg::OPT_RST_BIT];
        hclk = s_ff.opt[gp_pkg::OPT_HCLK_LSB +: 3];
        external_interrupt_0_edge = s_ff.opt[gp_pkg::OPT_EDGE_LSB +: 2];
        vref_en = s_ff.vref[gp_pkg::VREF_EN_BIT];
        chs = s_ff.adc_mode_control[2:0];
        conv_on = s_ff.adc_mode_control[gp_pkg::ADM_EN_BIT] & s_ff.adc_mode_control[gp_pkg::ADM_GLOBAL_CHANNEL_SELECT_BIT];
        osc_in_sel_out = (hclk == gp_pkg::HCLK_RC) || (hclk == gp_pkg::HCLK_32K)
            || (hclk == gp_pkg::HCLK_4M) || (hclk == gp_pkg::HCLK_12M);
        osc_out_sel_out = (hclk == gp_pkg::HCLK_32K)
            || (hclk == gp_pkg::HCLK_4M) || (hclk == gp_pkg::HCLK_12M);
        // the reset pin is low-active; its digital read is masked to 1
        ext_reset_out = opt_rst & ~p0_pin_in[4];
        adc_enable_out = s_ff.adc_mode_control[gp_pkg::ADM_EN_BIT];
        adc_internal_ch_out = conv_on && (chs == gp_pkg::CH_INTERNAL);
        // one decoded channel at most; the reference takes pin 0 from the adc
        for (int i = 0; i < 5; i++) begin
            p4_ain_out[i] = conv_on && (chs == 3'(i));
        end
        p4_ain_out[0] = p4_ain_out[0] & ~vref_en;
        p4_vref_out = s_ff.adc_mode_control[gp_pkg::ADM_EN_BIT] & vref_en;
        p4_ana = s_ff.p4_cfg | p4_ain_out | {4'h0, vref_en};
        t1_pwm_on = s_ff.share[gp_pkg::SH_T1_EN] & s_ff.share[gp_pkg::SH_TIMER1_PWM_PIN];
        t0_pwm_on = s_ff.share[gp_pkg::SH_T0_EN] & s_ff.share[gp_pkg::SH_TIMER0_PWM_PIN];
        // index 0 is pin 5.3 (timer 1), index 1 is pin 5.4 (timer 0)
        p5_alt_en[0] = t1_pwm_on
            | (s_ff.share[gp_pkg::SH_BUZ1] & ~s_ff.share[gp_pkg::SH_TIMER1_PWM_PIN]);
        p5_alt_val[0] = t1_pwm_on ? t1_pwm_in : t1_buzz_in;
        p5_alt_en[1] = t0_pwm_on
            | (s_ff.share[gp_pkg::SH_BUZ0] & ~s_ff.share[gp_pkg::SH_TIMER0_PWM_PIN]);
        p5_alt_val[1] = t0_pwm_on ? t0_pwm_in : t0_buzz_in;
        external_interrupt_0_level_out = s_ff.share[gp_pkg::SH_EXTERNAL_INTERRUPT_0_EN] & p0_pin_in[0];
        external_interrupt_1_level_out = s_ff.share[gp_pkg::SH_EXTERNAL_INTERRUPT_1_EN] & p0_pin_in[1];
        external_interrupt_0_pulse_out = s_ff.int_pls[0];
        external_interrupt_1_pulse_out = s_ff.int_pls[1];
        fell0 = s_ff.int_prev[0] & ~p0_pin_in[0];
        rose0 = ~s_ff.int_prev[0] & p0_pin_in[0];
        fell1 = s_ff.int_prev[1] & ~p0_pin_in[1];
    end

    // port 0 bit 4 has no cell at all: no driver, no pull-up
    gp_pin_cell #(
        .W(4)
    ) u_p0 (
        .dir_in(s_ff.p0_dir),
        .pu_in(s_ff.p0_pu),
        .lat_in(s_ff.p0_lat),
        .alt_en_in(4'h0),
        .alt_val_in(4'h0),
        .analog_in({osc_in_sel_out, osc_out_sel_out, 2'h0}),
        .pin_in(p0_pin_in[3:0]),
        .pin_out(p0_pin_out),
        .oe_out(p0_oe_out),
        .pu_out(p0_pu_out),
        .rd_out(p0_rd)
    );

    gp_pin_cell #(
        .W(5)
    ) u_p4 (
        .dir_in(s_ff.p4_dir),
        .pu_in(s_ff.p4_pu),
        .lat_in(s_ff.p4_lat),
        .alt_en_in(5'h00),
        .alt_val_in(5'h00),
        .analog_in(p4_ana),
        .pin_in(p4_pin_in),
        .pin_out(p4_pin_out),
        .oe_out(p4_oe_out),
        .pu_out(p4_pu_out),
        .rd_out(p4_rd)
    );

    gp_pin_cell #(
        .W(2)
    ) u_p5 (
        .dir_in(s_ff.p5_dir),
        .pu_in(s_ff.p5_pu),
        .lat_in(s_ff.p5_lat),
        .alt_en_in(p5_alt_en),
        .alt_val_in(p5_alt_val),
        .analog_in(2'h0),
        .pin_in(p5_pin_in),
        .pin_out(p5_pin_out),
        .oe_out(p5_oe_out),
        .pu_out(p5_pu_out),
        .rd_out(p5_rd)
    );

    // read decode; pull-up registers are write-only and read as zero
    always_comb begin
        rd_hit = 1'b1;
        rd_data = 8'h00;
        if (rd_idx == gp_pkg::IDX_P4_CFG) begin
            rd_data = {3'h0, s_ff.p4_cfg};
        end else if (rd_idx == gp_pkg::IDX_VREF) begin
            rd_data = s_ff.vref;
        end else if (rd_idx == gp_pkg::IDX_ADM) begin
            rd_data = s_ff.adc_mode_control;
        end else if (rd_idx == gp_pkg::IDX_P0_DIR) begin
            rd_data = {4'h0, s_ff.p0_dir};
        end else if (rd_idx == gp_pkg::IDX_P4_DIR) begin
            rd_data = {3'h0, s_ff.p4_dir};
        end else if (rd_idx == gp_pkg::IDX_P5_DIR) begin
            rd_data = {3'h0, s_ff.p5_dir, 3'h0};
        end else if (rd_idx == gp_pkg::IDX_P0_DAT) begin
            rd_data = {3'h0, opt_rst | p0_pin_in[4], p0_rd};
        end else if (rd_idx == gp_pkg::IDX_P4_DAT) begin
            rd_data = {3'h0, p4_rd};
        end else if (rd_idx == gp_pkg::IDX_P5_DAT) begin
            rd_data = {3'h0, p5_rd, 3'h0};
        end else if (rd_idx == gp_pkg::IDX_P0_PU) begin
            rd_data = 8'h00;
        end else if (rd_idx == gp_pkg::IDX_P4_PU) begin
            rd_data = 8'h00;
        end else if (rd_idx == gp_pkg::IDX_P5_PU) begin
            rd_data = 8'h00;
        end else if (rd_idx == gp_pkg::IDX_OPTION) begin
            rd_data = s_ff.opt;
        end else if (rd_idx == gp_pkg::IDX_SHARE) begin
            rd_data = s_ff.share;
        end else begin
            rd_hit = 1'b0;
        end
    end

    // write decode and interrupt edge detection
    always_comb begin
        s_nxt = s_ff;
        wr_hit = 1'b1;
        s_nxt.int_prev = p0_pin_in[1:0];
        s_nxt.int_pls[0] = s_ff.share[gp_pkg::SH_EXTERNAL_INTERRUPT_0_EN]
            & ((fell0 & (external_interrupt_0_edge != gp_pkg::EDGE_RISE))
            | (rose0 & (external_interrupt_0_edge != gp_pkg::EDGE_FALL)));
        s_nxt.int_pls[1] = s_ff.share[gp_pkg::SH_EXTERNAL_INTERRUPT_1_EN] & fell1;
        if (wr_idx == gp_pkg::IDX_P4_CFG) begin
            if (wr_en) s_nxt.p4_cfg = wr_dat[4:0];
        end else if (wr_idx == gp_pkg::IDX_VREF) begin
            if (wr_en) s_nxt.vref = wr_dat & gp_pkg::VREF_MASK;
        end else if (wr_idx == gp_pkg::IDX_ADM) begin
            if (wr_en) s_nxt.adc_mode_control = wr_dat & gp_pkg::ADM_MASK;
        end else if (wr_idx == gp_pkg::IDX_P0_DIR) begin
            if (wr_en) s_nxt.p0_dir = wr_dat[3:0];
        end else if (wr_idx == gp_pkg::IDX_P4_DIR) begin
            if (wr_en) s_nxt.p4_dir = wr_dat[4:0];
        end else if (wr_idx == gp_pkg::IDX_P5_DIR) begin
            if (wr_en) s_nxt.p5_dir = wr_dat[4:3];
        end else if (wr_idx == gp_pkg::IDX_P0_DAT) begin
            if (wr_en) s_nxt.p0_lat = wr_dat[3:0];
        end else if (wr_idx == gp_pkg::IDX_P4_DAT) begin
            if (wr_en) s_nxt.p4_lat = wr_dat[4:0];
        end else if (wr_idx == gp_pkg::IDX_P5_DAT) begin
            if (wr_en) s_nxt.p5_lat = wr_dat[4:3];
        end else if (wr_idx == gp_pkg::IDX_P0_PU) begin
            if (wr_en) s_nxt.p0_pu = wr_dat[3:0];
        end else if (wr_idx == gp_pkg::IDX_P4_PU) begin
            if (wr_en) s_nxt.p4_pu = wr_dat[4:0];
        end else if (wr_idx == gp_pkg::IDX_P5_PU) begin
            if (wr_en) s_nxt.p5_pu = wr_dat[4:3];
        end else if (wr_idx == gp_pkg::IDX_OPTION) begin
            if (wr_en) s_nxt.opt = wr_dat & gp_pkg::OPT_MASK;
        end else if (wr_idx == gp_pkg::IDX_SHARE) begin
            if (wr_en) s_nxt.share = wr_dat;
        end else begin
            wr_hit = 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            s_ff <= '0;
        end else begin
            s_ff <= s_nxt;
        end
    end

    default clocking gp_cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    a_dir_drives_pin: assert property (
        p0_oe_out[1:0] == s_ff.p0_dir[1:0]
    ) else $error("port 0 enable does not follow direction");

    a_pullup_input: assert property (
        ((p4_pu_out & p4_oe_out) == 5'h00) && ((p4_pu_out & ~s_ff.p4_pu) == 5'h00)
    ) else $error("pull-up active on output or disabled pin");

    a_p04_dir_empty: assert property (
        (rd_idx == gp_pkg::IDX_P0_DIR)
        |-> rd_data[7:4] == 4'h0
    ) else $error("port 0 direction bit 4 retained");

    a_reset_pin_one: assert property (
        (opt_rst && rd_idx == gp_pkg::IDX_P0_DAT) |-> rd_data[4]
    ) else $error("reset pin data not read as one");

    a_t1_pwm_route: assert property (
        t1_pwm_on |-> (p5_oe_out[0] && p5_pin_out[0] == t1_pwm_in)
    ) else $error("timer 1 pwm not on port 5 bit 3");

    a_pure_analog: assert property (
        ((s_ff.p4_cfg & (p4_oe_out | p4_pu_out | p4_pin_out)) == 5'h00)
    ) else $error("pure analog pin has digital path");

    a_one_channel: assert property (
        $onehot0(p4_ain_out) && (conv_on || (p4_ain_out == 5'h00))
    ) else $error("more than one adc pin routed");

    a_ext_reference: assert property (
        vref_en |-> (!p4_ain_out[0] && !p4_oe_out[0] && !p4_pu_out[0])
    ) else $error("reference pin kept digital or adc use");

    a_reset_clears: assert property (
        $past(rst_in) |-> (s_ff == '0)
    ) else $error("state not zero after reset");

    a_external_interrupt_1_falling: assert property (
        (s_ff.share[gp_pkg::SH_EXTERNAL_INTERRUPT_1_EN] && $fell(p0_pin_in[1]))
        |-> ##1 external_interrupt_1_pulse_out ##1 !external_interrupt_1_pulse_out || $fell(p0_pin_in[1])
    ) else $error("external_interrupt_1 falling edge missed");

    a_latch_write: assert property (
        (wr_en && wr_idx == gp_pkg::IDX_P4_DAT) |=> s_ff.p4_lat == $past(wr_dat[4:0])
    ) else $error("port 4 latch not written");
endmodule : gp_gpio_top

// File: tb/gp_board.sv
// board circuitry on one port: pin driver first, then pull-up, then outside source
`timescale 1ns/10ps
module gp_board #(
    parameter int W = 1
) (
    input wire logic [W-1:0] oe_in,
    input wire logic [W-1:0] drv_in,
    input wire logic [W-1:0] pu_in,
    input wire logic [W-1:0] ext_in,
    output logic [W-1:0] pin_out
);
    // outside source is weak, so a pull-up wins over it
    always_comb begin
        for (int i = 0; i < W; i++) begin
            pin_out[i] = oe_in[i] ? drv_in[i] : (pu_in[i] ? 1'b1 : ext_in[i]);
        end
    end
endmodule : gp_board

// File: tb/gp_gpio_top_tb.sv
// register-level tests of the gpio port block
`timescale 1ns/10ps
module gp_gpio_top_tb;
    logic clk_in, rst_in, t0p, t0b, t1p, t1b, adc_en, adc_int, ext_rst, osc_i, osc_o;
    logic i0l, i1l, i0p, i1p, vref;
    logic [1:0] seen;
    gp_pkg::gp_axil_req_s req;
    gp_pkg::gp_axil_rsp_s rsp;
    logic [4:0] p0_pin, p0_ext, p4_pin, p4_ext, p4_drv, p4_oe, p4_pu, p4_ain, e;
    logic [3:0] p0_drv, p0_oe, p0_pu;
    logic [1:0] p5_pin, p5_ext, p5_drv, p5_oe, p5_pu, rr;
    logic [31:0] rd;
    int error_cnt, n_compared, cyc;

    gp_gpio_top i_gp_gpio_top (.clk_in(clk_in), .rst_in(rst_in), .axil_req_in(req),
        .axil_rsp_out(rsp), .p0_pin_in(p0_pin), .p0_pin_out(p0_drv), .p0_oe_out(p0_oe),
        .p0_pu_out(p0_pu), .p4_pin_in(p4_pin), .p4_pin_out(p4_drv), .p4_oe_out(p4_oe),
        .p4_pu_out(p4_pu), .p4_ain_out(p4_ain), .p4_vref_out(vref), .p5_pin_in(p5_pin),
        .p5_pin_out(p5_drv), .p5_oe_out(p5_oe), .p5_pu_out(p5_pu), .t0_pwm_in(t0p),
        .t0_buzz_in(t0b), .t1_pwm_in(t1p), .t1_buzz_in(t1b), .adc_enable_out(adc_en),
        .adc_internal_ch_out(adc_int), .ext_reset_out(ext_rst), .osc_in_sel_out(osc_i),
        .osc_out_sel_out(osc_o), .external_interrupt_0_level_out(i0l), .external_interrupt_1_level_out(i1l),
        .external_interrupt_0_pulse_out(i0p), .external_interrupt_1_pulse_out(i1p));
    gp_board #(.W(5)) i_board_p0 (.oe_in({1'b0, p0_oe}), .drv_in({1'b0, p0_drv}),
        .pu_in({1'b0, p0_pu}), .ext_in(p0_ext), .pin_out(p0_pin));
    gp_board #(.W(5)) i_board_p4 (.oe_in(p4_oe), .drv_in(p4_drv), .pu_in(p4_pu),
        .ext_in(p4_ext), .pin_out(p4_pin));
    gp_board #(.W(2)) i_board_p5 (.oe_in(p5_oe), .drv_in(p5_drv), .pu_in(p5_pu),
        .ext_in(p5_ext), .pin_out(p5_pin));

    task automatic give_verdict();
        $display("compared %0d, errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // bready and rready stay high, so each response is taken at its first valid edge
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic aw, w;
        aw = 1'b0;
        w = 1'b0;
        @(posedge clk_in);
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.awaddr <= {2'h0, idx, 2'h0};
        req.wdata <= {24'h0, d};
        while (!(aw && w)) begin
            @(negedge clk_in);
            aw = aw | (req.awvalid & rsp.awready);
            w = w | (req.wvalid & rsp.wready);
            @(posedge clk_in);
            if (aw) req.awvalid <= 1'b0;
            if (w) req.wvalid <= 1'b0;
        end
        do @(negedge clk_in); while (rsp.bvalid !== 1'b1);
        @(posedge clk_in);
    endtask : wr

    task automatic rck(input logic [7:0] idx, input logic [7:0] exp, input logic [1:0] er);
        @(posedge clk_in);
        req.arvalid <= 1'b1;
        req.araddr <= {2'h0, idx, 2'h0};
        do @(negedge clk_in); while (rsp.arready !== 1'b1);
        @(posedge clk_in);
        req.arvalid <= 1'b0;
        do @(negedge clk_in); while (rsp.rvalid !== 1'b1);
        rd = rsp.rdata;
        rr = rsp.rresp;
        @(posedge clk_in);
        chk(rd, {24'h0, exp});
        chk(32'(rr), 32'(er));
    endtask : rck

    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end

    // cycle ceiling well above the few hundred cycles the sequence needs
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            $display("[ERR] %0t timeout", $time);
            give_verdict();
        end
    end

    initial begin
        rst_in = 1'b1;
        req = '0;
        req.bready = 1'b1;
        req.rready = 1'b1;
        req.wstrb = 4'hF;
        {t0p, t0b, t1p, t1b, p0_ext, p4_ext, p5_ext} = '0;
        repeat (10) @(posedge clk_in);
        rst_in <= 1'b0;
        rck(gp_pkg::IDX_P4_CFG, 8'h00, gp_pkg::RESP_OKAY);
        rck(gp_pkg::IDX_VREF, 8'h00, gp_pkg::RESP_OKAY);
        rck(gp_pkg::IDX_ADM, 8'h00, gp_pkg::RESP_OKAY);
        rck(gp_pkg::IDX_P0_DIR, 8'h00, gp_pkg::RESP_OKAY);
        rck(gp_pkg::IDX_P4_DIR, 8'h00, gp_pkg::RESP_OKAY);
        rck(gp_pkg::IDX_P5_DAT, 8'h00, gp_pkg::RESP_OKAY);
        rck(gp_pkg::IDX_P0_PU, 8'h00, gp_pkg::RESP_OKAY);
        rck(8'h00, 8'h00, gp_pkg::RESP_SLVERR);
        chk({p0_oe, p4_oe, p5_oe, p0_pu, p4_pu}, 32'h0);
        p4_ext <= 5'h0A;
        wr(gp_pkg::IDX_P4_DAT, 8'h15);
        wr(gp_pkg::IDX_P4_DIR, 8'h0F);
        wr(gp_pkg::IDX_P4_PU, 8'h1F);
        @(negedge clk_in);
        chk(p4_oe, 5'h0F);
        chk(p4_pu, 5'h10);
        chk(p4_drv, 5'h15);
        rck(gp_pkg::IDX_P4_DAT, 8'h15, gp_pkg::RESP_OKAY);
        wr(gp_pkg::IDX_P4_CFG, 8'h02);
        @(negedge clk_in);
        chk(p4_oe, 5'h0D);
        wr(gp_pkg::IDX_P4_CFG, 8'h00);
        for (int c = 0; c < 6; c++) begin
            wr(gp_pkg::IDX_ADM, 8'h90 | 8'(c));
            @(negedge clk_in);
            e = (c < 5) ? 5'(1 << c) : 5'h00;
            chk(p4_ain, e);
            chk(p4_oe, 5'h0F & ~e);
            chk(adc_int, c == 5);
        end
        wr(gp_pkg::IDX_ADM, 8'h82);
        @(negedge clk_in);
        chk({adc_en, p4_ain, p4_oe}, 11'h40F);
        wr(gp_pkg::IDX_ADM, 8'h90);
        wr(gp_pkg::IDX_VREF, 8'h80);
        @(negedge clk_in);
        chk({vref, p4_ain[0], p4_oe[0]}, 3'b100);
        wr(gp_pkg::IDX_VREF, 8'h00);
        wr(gp_pkg::IDX_P0_DIR, 8'hFF);
        wr(gp_pkg::IDX_P0_PU, 8'hFF);
        @(negedge clk_in);
        chk({p0_oe, p0_pu, p0_drv}, 12'hF00);
        rck(gp_pkg::IDX_P0_DIR, 8'h0F, gp_pkg::RESP_OKAY);
        wr(gp_pkg::IDX_P0_DIR, 8'h00);
        wr(gp_pkg::IDX_OPTION, 8'h01);
        @(negedge clk_in);
        chk({p0_oe, p0_pu, ext_rst}, 9'h01F);
        rck(gp_pkg::IDX_P0_DAT, 8'h1F, gp_pkg::RESP_OKAY);
        for (int h = 0; h < 5; h++) begin
            wr(gp_pkg::IDX_OPTION, 8'(h * 2));
            @(negedge clk_in);
            chk({osc_i, osc_o, ext_rst}, {h >= 1, h >= 2, 1'b0});
        end
        wr(gp_pkg::IDX_OPTION, 8'h00);
        rck(gp_pkg::IDX_P0_DAT, 8'h0F, gp_pkg::RESP_OKAY);
        t0p <= 1'b1;
        t1b <= 1'b1;
        wr(gp_pkg::IDX_SHARE, 8'h05);
        @(negedge clk_in);
        chk({p5_oe[1], p5_drv[1]}, 2'b11);
        wr(gp_pkg::IDX_P5_PU, 8'h18);
        wr(gp_pkg::IDX_SHARE, 8'h20);
        @(negedge clk_in);
        chk({p5_oe, p5_drv, p5_pu}, 6'b010110);
        wr(gp_pkg::IDX_SHARE, 8'h3C);
        @(negedge clk_in);
        chk(p5_oe, 2'b00);
        wr(gp_pkg::IDX_P0_PU, 8'h00);
        p0_ext <= 5'h03;
        wr(gp_pkg::IDX_SHARE, 8'hC0);
        @(negedge clk_in);
        chk({i1l, i0l}, 2'b11);
        @(posedge clk_in);
        p0_ext <= 5'h00;
        seen = 2'b00;
        repeat (3) @(negedge clk_in) seen |= {i1p, i0p};
        chk(seen, 2'b11);
        // external_interrupt_0 now rising only; external_interrupt_1 must stay silent on a rise
        wr(gp_pkg::IDX_OPTION, 8'h10);
        @(posedge clk_in);
        p0_ext <= 5'h03;
        seen = 2'b00;
        repeat (3) @(negedge clk_in) seen |= {i1p, i0p};
        chk(seen, 2'b01);
        give_verdict();
    end
endmodule : gp_gpio_top_tb
